//--- pscr_router.sv
// Power switch control router: source selection, mapping, delays, switch decode, status word
`include "pscr_map.svh"
module pscr_router
  import pscr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic statusWrite,
  input wire pscr_status_t statusWriteData,
  input wire logic masterEnable,
  input wire logic softTriggerSignal,
  input wire logic softTriggerOut,
  input wire logic oscillatorPulse,
  input wire logic [6:0] terminalInput,
  input wire pscr_quad_t generatorOutput,
  input wire pscr_quad_t generatorRunning,
  input wire pscr_sel_t [3:0] triggerSourceSelect,
  input wire pscr_sel_t [3:0] enableSourceSelect,
  input wire pscr_quad_t triggerInvert,
  input wire pscr_quad_t enableInvert,
  input wire pscr_dly_t [3:0] triggerRiseDelay,
  input wire pscr_dly_t [3:0] triggerFallDelay,
  input wire pscr_dly_t [3:0] enableDelay,
  input wire logic mapEnable,
  input wire pscr_map_target_t mapTarget,
  input wire pscr_quad_t [4:0] mapPattern,
  input wire logic [1:0] trilevelPair,
  output pscr_status_t statusRead,
  output logic oscillatorOn,
  output logic generatorsOn,
  output logic softTriggerIn,
  output logic softPulseIn,
  output logic ditherOff,
  output logic supplyClearN,
  output pscr_quad_t channelTrigger,
  output pscr_quad_t channelEnable,
  output pscr_quad_t branchNegOn,
  output pscr_quad_t branchPosOn,
  output logic [1:0] branchMidOn
);
  pscr_status_t status_reg;
  logic [6:0] termMeta_reg;
  logic [6:0] termSync_reg;
  logic oscPrev_reg;
  logic [1:0] oscCount_reg;
  logic oscShaped_reg;
  pscr_quad_t trigPick_reg;
  pscr_quad_t enbPick_reg;
  pscr_quad_t trigMap_reg;
  pscr_quad_t enbMap_reg;
  logic oscillatorOn_reg;
  logic generatorsOn_reg;
  logic supplyClearN_reg;
  pscr_quad_t negOn_reg;
  pscr_quad_t posOn_reg;
  logic [1:0] midOn_reg;
  pscr_status_t statusRead_reg;

  logic [`PSCR_SRC_COUNT-1:0] srcVec;
  pscr_quad_t trigPick_next;
  pscr_quad_t enbPick_next;
  pscr_quad_t mapIn;
  pscr_quad_t mapOut;
  pscr_quad_t trigMap_next;
  pscr_quad_t enbMap_next;
  pscr_quad_t trigDly;
  pscr_quad_t enbDly;
  pscr_quad_t effEnb;
  pscr_quad_t negOn_next;
  pscr_quad_t posOn_next;
  logic [1:0] midOn_next;
  logic switchesOn;
  logic supplyClearN_next;
  pscr_status_t statusRead_next;
  logic oscStart;

  // Source picker, shared by all eight controls
  function automatic logic srcPick(input logic [`PSCR_SRC_COUNT-1:0] src,
                                   input pscr_sel_t sel, input logic inv);
    logic bit_val;
    bit_val = (sel < 5'(`PSCR_SRC_COUNT)) ? src[sel] : 1'b0;
    return bit_val ^ inv;
  endfunction : srcPick

  // Mapping priority encoder, input 0 highest
  function automatic pscr_quad_t mapPick(input pscr_quad_t in, input pscr_quad_t [4:0] pat);
    pscr_quad_t res;
    res = pat[0];
    if (in[0]) res = pat[1];
    else if (in[1]) res = pat[2];
    else if (in[2]) res = pat[3];
    else if (in[3]) res = pat[4];
    return res;
  endfunction : mapPick

  // Source vector ordered by select code
  assign srcVec = {generatorRunning, generatorOutput, termSync_reg, oscShaped_reg,
                   softTriggerSignal, 1'b0};

  // Multiplexers and inversion for all channels
  genvar ch;
  generate
    for (ch = 0; ch < `PSCR_CHANNELS; ch++) begin : g_pick
      assign trigPick_next[ch] = srcPick(srcVec, triggerSourceSelect[ch], triggerInvert[ch]);
      assign enbPick_next[ch] = srcPick(srcVec, enableSourceSelect[ch], enableInvert[ch]);
    end
  endgenerate

  // Mapping engine or straight pass
  assign mapIn = (mapTarget == PSCR_MAP_ENABLE) ? enbPick_reg : trigPick_reg;
  assign mapOut = mapPick(mapIn, mapPattern);
  assign trigMap_next = (mapEnable && mapTarget == PSCR_MAP_TRIGGER) ? mapOut : trigPick_reg;
  assign enbMap_next = (mapEnable && mapTarget == PSCR_MAP_ENABLE) ? mapOut : enbPick_reg;

  // Fine delay stages, one per trigger and per enable
  pscr_delay_if trigLink [3:0] ();
  pscr_delay_if enbLink [3:0] ();
  generate
    for (ch = 0; ch < `PSCR_CHANNELS; ch++) begin : g_dly
      assign trigLink[ch].clkEn = clkEn;
      assign trigLink[ch].sigIn = trigMap_reg[ch];
      assign trigLink[ch].riseSel = triggerRiseDelay[ch];
      assign trigLink[ch].fallSel = triggerFallDelay[ch];
      assign trigDly[ch] = trigLink[ch].sigOut;
      assign enbLink[ch].clkEn = clkEn;
      assign enbLink[ch].sigIn = enbMap_reg[ch];
      assign enbLink[ch].riseSel = enableDelay[ch];
      assign enbLink[ch].fallSel = enableDelay[ch];
      assign enbDly[ch] = enbLink[ch].sigOut;
      pscr_fine_delay u_trig (.ref_clk(ref_clk), .reset_n(reset_n), .dly(trigLink[ch]));
      pscr_fine_delay u_enb (.ref_clk(ref_clk), .reset_n(reset_n), .dly(enbLink[ch]));
    end
  endgenerate

  // Switch decode, dual-level or trilevel per pair
  assign switchesOn = status_reg[`PSCR_ST_ENB];
  assign effEnb = switchesOn ? enbDly : 4'h0;
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pair
      logic tLo;
      logic tHi;
      logic eLo;
      logic eHi;
      assign tLo = trigDly[2*p];
      assign tHi = trigDly[2*p+1];
      assign eLo = effEnb[2*p];
      assign eHi = effEnb[2*p+1];
      // Trilevel: lower channel negative, upper channel positive
      assign posOn_next[2*p+1] = trilevelPair[p] ? (eHi & tHi) : (eHi & tHi);
      assign negOn_next[2*p] = trilevelPair[p] ? (eLo & ~tLo & ~(eHi & tHi)) : (eLo & ~tLo);
      assign midOn_next[p] = trilevelPair[p] & eLo & eHi & tLo & ~tHi;
      assign posOn_next[2*p] = trilevelPair[p] ? 1'b0 : (eLo & tLo);
      assign negOn_next[2*p+1] = trilevelPair[p] ? 1'b0 : (eHi & ~tHi);
    end
  endgenerate

  // Supply clear and status read-back
  assign supplyClearN_next = !(!masterEnable
                              || (!status_reg[`PSCR_ST_ENB] && !status_reg[`PSCR_ST_KEEP]));
  assign statusRead_next = {supplyClearN_reg, softTriggerOut, masterEnable, 1'b0,
                            status_reg[6:0]};
  assign oscStart = oscillatorPulse && !oscPrev_reg;

  // Writable status bits
  always_ff @(posedge ref_clk) begin
    if (!reset_n) status_reg <= `PSCR_ST_RESET;
    else if (clkEn && statusWrite) status_reg <= statusWriteData & `PSCR_ST_WMASK;
  end

  // Terminal input synchroniser
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      termMeta_reg <= 7'h00;
      termSync_reg <= 7'h00;
    end else if (clkEn) begin
      termMeta_reg <= terminalInput;
      termSync_reg <= termMeta_reg;
    end
  end

  // Oscillator pulse shaped to one 10 ns period
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      oscPrev_reg <= 1'b0;
      oscCount_reg <= 2'h0;
      oscShaped_reg <= 1'b0;
    end else if (clkEn) begin
      oscPrev_reg <= oscillatorPulse;
      if (oscStart) begin
        oscCount_reg <= 2'(`PSCR_OSC_CYCLES - 1);
        oscShaped_reg <= 1'b1;
      end else if (oscCount_reg != 2'h0) begin
        oscCount_reg <= oscCount_reg - 2'h1;
      end else begin
        oscShaped_reg <= 1'b0;
      end
    end
  end

  // Selection and mapping stages
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      trigPick_reg <= 4'h0;
      enbPick_reg <= 4'h0;
      trigMap_reg <= 4'h0;
      enbMap_reg <= 4'h0;
    end else if (clkEn) begin
      trigPick_reg <= trigPick_next;
      enbPick_reg <= enbPick_next;
      trigMap_reg <= trigMap_next;
      enbMap_reg <= enbMap_next;
    end
  end

  // Output flip-flops
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      oscillatorOn_reg <= 1'b0;
      generatorsOn_reg <= 1'b0;
      supplyClearN_reg <= 1'b0;
      negOn_reg <= 4'h0;
      posOn_reg <= 4'h0;
      midOn_reg <= 2'h0;
      statusRead_reg <= `PSCR_ST_RESET;
    end else if (clkEn) begin
      oscillatorOn_reg <= status_reg[`PSCR_ST_OSC] && switchesOn && masterEnable;
      generatorsOn_reg <= status_reg[`PSCR_ST_GEN] && switchesOn && masterEnable;
      supplyClearN_reg <= supplyClearN_next;
      negOn_reg <= negOn_next;
      posOn_reg <= posOn_next;
      midOn_reg <= midOn_next;
      statusRead_reg <= statusRead_next;
    end
  end

  assign statusRead = statusRead_reg;
  assign oscillatorOn = oscillatorOn_reg;
  assign generatorsOn = generatorsOn_reg;
  assign softTriggerIn = status_reg[`PSCR_ST_STRIG];
  assign softPulseIn = status_reg[`PSCR_ST_SPULSE];
  assign ditherOff = status_reg[`PSCR_ST_DITHER];
  assign supplyClearN = supplyClearN_reg;
  assign channelTrigger = trigDly;
  assign channelEnable = enbDly;
  assign branchNegOn = negOn_reg;
  assign branchPosOn = posOn_reg;
  assign branchMidOn = midOn_reg;

  // Checks on the router behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n || !clkEn);

  property p_dual_off;
    (!trilevelPair[0] && !effEnb[0]) |=> (!branchNegOn[0] && !branchPosOn[0]);
  endproperty
  a_dual_off: assert property (p_dual_off) else $error("dual channel not off");

  property p_dual_trig;
    (!trilevelPair[0] && effEnb[0]) |=> (branchPosOn[0] == $past(trigDly[0])
                                         && branchNegOn[0] == !$past(trigDly[0]));
  endproperty
  a_dual_trig: assert property (p_dual_trig) else $error("dual branch wrong");

  property p_sel_zero;
    (triggerSourceSelect[0] == `PSCR_SEL_ZERO) |=> (trigPick_reg[0] == $past(triggerInvert[0]));
  endproperty
  a_sel_zero: assert property (p_sel_zero) else $error("zero source wrong");

  property p_sel_soft;
    (enableSourceSelect[1] == `PSCR_SEL_SOFT) |=>
      (enbPick_reg[1] == ($past(softTriggerSignal) ^ $past(enableInvert[1])));
  endproperty
  a_sel_soft: assert property (p_sel_soft) else $error("soft source wrong");

  property p_tri_mid;
    (trilevelPair[0] && effEnb[1:0] == 2'h3 && trigDly[1:0] == 2'h1)
      |=> (branchMidOn[0] && !branchNegOn[0] && !branchPosOn[1]);
  endproperty
  a_tri_mid: assert property (p_tri_mid) else $error("middle level wrong");

  property p_tri_single;
    (trilevelPair[1] && effEnb[3:2] == 2'h1 && trigDly[2]) |=> (branchNegOn[3:2] == 2'h0
      && !branchMidOn[1] && !branchPosOn[3]);
  endproperty
  a_tri_single: assert property (p_tri_single) else $error("single branch wrong");

  property p_map_prio;
    (mapEnable && mapTarget == PSCR_MAP_TRIGGER && trigPick_reg[0]) |=>
      (trigMap_reg == $past(mapPattern[1]));
  endproperty
  a_map_prio: assert property (p_map_prio) else $error("map priority wrong");

  property p_stop;
    !status_reg[`PSCR_ST_ENB] |=> (!oscillatorOn && !generatorsOn);
  endproperty
  a_stop: assert property (p_stop) else $error("oscillator not stopped");

  property p_keep;
    (status_reg[`PSCR_ST_KEEP] && masterEnable) |=> supplyClearN;
  endproperty
  a_keep: assert property (p_keep) else $error("supply cleared while kept");

  property p_master;
    !masterEnable |=> (!supplyClearN && !oscillatorOn && !generatorsOn);
  endproperty
  a_master: assert property (p_master) else $error("master enable ignored");

  sequence s_osc_high;
    oscShaped_reg [*2];
  endsequence
  property p_osc_pulse;
    (oscStart && oscCount_reg == 2'h0) |=> s_osc_high ##1 (!oscShaped_reg || $past(oscStart));
  endproperty
  a_osc_pulse: assert property (p_osc_pulse) else $error("oscillator pulse width wrong");
endmodule : pscr_router

//--- pscr_map.svh
// Constants of the power switch control router
`ifndef PSCR_MAP_SVH
`define PSCR_MAP_SVH
`define PSCR_CHANNELS 4
`define PSCR_SEL_W 5
`define PSCR_SRC_COUNT 18
`define PSCR_SEL_ZERO 5'h00
`define PSCR_SEL_SOFT 5'h01
`define PSCR_SEL_OSC 5'h02
`define PSCR_SEL_TERM 5'h03
`define PSCR_SEL_GEN 5'h0a
`define PSCR_SEL_RUN 5'h0e
`define PSCR_TERM_COUNT 7
`define PSCR_GEN_COUNT 4
`define PSCR_DLY_W 4
`define PSCR_DLY_TAPS 16
`define PSCR_PAT_COUNT 5
`define PSCR_ST_W 11
`define PSCR_ST_ENB 0
`define PSCR_ST_OSC 1
`define PSCR_ST_GEN 2
`define PSCR_ST_STRIG 3
`define PSCR_ST_SPULSE 4
`define PSCR_ST_KEEP 5
`define PSCR_ST_DITHER 6
`define PSCR_ST_MASTER 8
`define PSCR_ST_SOUT 9
`define PSCR_ST_SUPPLY_CLEAR_N 10
`define PSCR_ST_WMASK 11'h07f
`define PSCR_ST_RESET 11'h000
`define PSCR_CLK_NS 5
`define PSCR_OSC_PULSE_NS 10
`define PSCR_OSC_CYCLES ((`PSCR_OSC_PULSE_NS + `PSCR_CLK_NS - 1) / `PSCR_CLK_NS)
`endif

//--- pscr_pkg.sv
// Types of the power switch control router
package pscr_pkg;
  typedef logic [4:0] pscr_sel_t;
  typedef logic [3:0] pscr_dly_t;
  typedef logic [3:0] pscr_quad_t;
  typedef logic [10:0] pscr_status_t;
  typedef enum logic {PSCR_MAP_TRIGGER, PSCR_MAP_ENABLE} pscr_map_target_t;
endpackage : pscr_pkg

//--- pscr_delay_if.sv
// Link between the router core and one fine delay stage
interface pscr_delay_if;
  import pscr_pkg::*;
  logic clkEn;
  logic sigIn;
  pscr_dly_t riseSel;
  pscr_dly_t fallSel;
  logic sigOut;
  modport core (output clkEn, output sigIn, output riseSel, output fallSel, input sigOut);
  modport stage (input clkEn, input sigIn, input riseSel, input fallSel, output sigOut);
endinterface : pscr_delay_if

//--- pscr_fine_delay.sv
// Fine delay stage with separate rising and falling delay taps
`include "pscr_map.svh"
module pscr_fine_delay
  import pscr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  pscr_delay_if.stage dly
);
  logic [`PSCR_DLY_TAPS-2:0] line_reg;
  logic out_reg;
  logic [`PSCR_DLY_TAPS-1:0] taps;
  logic riseTap;
  logic fallTap;
  logic out_next;
  logic riseFirst;

  // Tap 0 is the undelayed input
  assign taps = {line_reg, dly.sigIn};
  assign riseTap = taps[dly.riseSel];
  assign fallTap = taps[dly.fallSel];
  // Rising slope follows the rise tap, falling slope the fall tap; the earlier tap
  // must agree too, so the output never bounces after an edge. Pulses shorter than
  // the gap between the two taps come out short or vanish.
  assign riseFirst = (dly.riseSel <= dly.fallSel);
  assign out_next = out_reg ? (fallTap | (riseFirst & riseTap))
                            : (riseTap & (riseFirst | fallTap));
  assign dly.sigOut = out_reg;

  // Delay line and output state
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      line_reg <= '0;
      out_reg <= 1'b0;
    end else if (dly.clkEn) begin
      line_reg <= taps[`PSCR_DLY_TAPS-2:0];
      out_reg <= out_next;
    end
  end
endmodule : pscr_fine_delay

//--- pscr_switch_driver.sv
// Behavioural bank of power switch drivers at the router's far side
module pscr_switch_driver
  import pscr_pkg::*;
(
  input wire logic ref_clk,
  input wire pscr_quad_t branchNegOn,
  input wire pscr_quad_t branchPosOn,
  input wire logic [1:0] branchMidOn,
  output int shortCount
);
  timeunit 1ns;
  timeprecision 100ps;
  int shorts = 0;
  logic [1:0] pairBusy;
  assign shortCount = shorts;
  assign pairBusy = {branchPosOn[3] | branchNegOn[2], branchPosOn[1] | branchNegOn[0]};
  // Two branches of one stage on together would short its rails
  always @(posedge ref_clk) begin
    if (((branchNegOn & branchPosOn) != 4'h0) || ((branchMidOn & pairBusy) != 2'h0)) begin
      shorts <= shorts + 1;
    end
  end
endmodule : pscr_switch_driver

//--- power_switch_control_router_test.sv
// Self-checking bench of the power switch control router
`include "pscr_map.svh"
module power_switch_control_router_test
  import pscr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic refClk = 1'b0;
  logic resetN, clkEn, statusWrite, masterEnable, softTriggerSignal, softTriggerOut;
  logic oscillatorPulse, mapEnable, oscillatorOn, generatorsOn, softTriggerIn, softPulseIn;
  logic ditherOff, supplyClearN;
  pscr_status_t statusWriteData, statusRead;
  logic [6:0] terminalInput, stModel;
  pscr_quad_t generatorOutput, generatorRunning, triggerInvert, enableInvert;
  pscr_quad_t channelTrigger, channelEnable, branchNegOn, branchPosOn;
  pscr_sel_t [3:0] triggerSourceSelect, enableSourceSelect;
  pscr_dly_t [3:0] triggerRiseDelay, triggerFallDelay, enableDelay;
  pscr_map_target_t mapTarget;
  pscr_quad_t [4:0] mapPattern;
  logic [1:0] trilevelPair, branchMidOn;
  logic [31:0] rngState = 32'hb8c04ae9;
  logic [31:0] r;
  int mismatches = 0;
  int samplesChecked = 0;
  int shortCount, n;

  pscr_router pscr_router_inst (
    .ref_clk(refClk), .reset_n(resetN), .clkEn, .statusWrite, .statusWriteData,
    .masterEnable, .softTriggerSignal, .softTriggerOut, .oscillatorPulse, .terminalInput,
    .generatorOutput, .generatorRunning, .triggerSourceSelect, .enableSourceSelect,
    .triggerInvert, .enableInvert, .triggerRiseDelay, .triggerFallDelay, .enableDelay,
    .mapEnable, .mapTarget, .mapPattern, .trilevelPair, .statusRead, .oscillatorOn,
    .generatorsOn, .softTriggerIn, .softPulseIn, .ditherOff, .supplyClearN,
    .channelTrigger, .channelEnable, .branchNegOn, .branchPosOn, .branchMidOn
  );
  pscr_switch_driver pscr_switch_driver_inst (
    .ref_clk(refClk), .branchNegOn, .branchPosOn, .branchMidOn, .shortCount
  );

  // 200 MHz clock
  always #2.5 refClk = ~refClk;

  function automatic logic [31:0] xorshift();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState;
  endfunction : xorshift

  // Steady level of one source code; oscillator held still reads 0
  function automatic logic src(pscr_sel_t s);
    logic [17:0] v;
    v = {generatorRunning, generatorOutput, terminalInput, 1'b0, softTriggerSignal, 1'b0};
    return (s < 5'h12) ? v[s] : 1'b0;
  endfunction : src

  task automatic check(string what, logic [31:0] expected, logic [31:0] seen);
    samplesChecked++;
    if (seen !== expected) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, expected, seen);
    end
  endtask : check

  task automatic check_count(string what, int expected, int seen);
    samplesChecked++;
    if (seen != expected) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, expected, seen);
    end
  endtask : check_count

  task automatic settle(int cycles);
    repeat (cycles) @(negedge refClk);
  endtask : settle

  task automatic end_test(string name);
    $display("test %s done", name);
  endtask : end_test

  task automatic write_status(pscr_status_t d);
    statusWriteData = d;
    statusWrite = 1'b1;
    @(negedge refClk);
    statusWrite = 1'b0;
    if (clkEn) stModel = d[6:0];
  endtask : write_status

  // Reference model of every steady output
  task automatic compare_all();
    logic [3:0] t, e, m, neg, pos;
    logic [1:0] mid;
    logic sc;
    int idx;
    for (int c = 0; c < 4; c++) begin
      t[c] = src(triggerSourceSelect[c]) ^ triggerInvert[c];
      e[c] = src(enableSourceSelect[c]) ^ enableInvert[c];
    end
    m = (mapTarget == PSCR_MAP_ENABLE) ? e : t;
    idx = m[0] ? 1 : m[1] ? 2 : m[2] ? 3 : m[3] ? 4 : 0;
    if (mapEnable && mapTarget == PSCR_MAP_ENABLE) e = mapPattern[idx];
    if (mapEnable && mapTarget == PSCR_MAP_TRIGGER) t = mapPattern[idx];
    check("channelTrigger", t, channelTrigger);
    check("channelEnable", e, channelEnable);
    e = e & {4{stModel[0]}};
    neg = e & ~t;
    pos = e & t;
    mid = 2'b00;
    for (int p = 0; p < 2; p++) begin
      if (trilevelPair[p]) begin
        pos[2 * p] = 1'b0;
        neg[2 * p + 1] = 1'b0;
        neg[2 * p] = e[2 * p] & ~t[2 * p] & ~pos[2 * p + 1];
        mid[p] = e[2 * p] & e[2 * p + 1] & t[2 * p] & ~t[2 * p + 1];
      end
    end
    check("branches", {neg, pos, mid}, {branchNegOn, branchPosOn, branchMidOn});
    sc = masterEnable & (stModel[0] | stModel[5]);
    check("statusRead", {sc, softTriggerOut, masterEnable, 1'b0, stModel}, statusRead);
    check("statusOuts", {stModel[1] & stModel[0] & masterEnable,
      stModel[2] & stModel[0] & masterEnable, stModel[3], stModel[4], stModel[6], sc},
      {oscillatorOn, generatorsOn, softTriggerIn, softPulseIn, ditherOff, supplyClearN});
  endtask : compare_all

  // Edge latencies of trigger and enable on channel 0
  task automatic measure(int rt, int ft, int et);
    int tn, en, ts, es;
    triggerRiseDelay[0] = pscr_dly_t'(rt);
    triggerFallDelay[0] = pscr_dly_t'(ft);
    enableDelay[0] = pscr_dly_t'(et);
    settle(30);
    for (int lvl = 1; lvl >= 0; lvl--) begin
      softTriggerSignal = lvl[0];
      tn = -1;
      en = -1;
      ts = 0;
      es = 0;
      for (int k = 1; k <= 40; k++) begin
        @(negedge refClk);
        if (tn < 0 && channelTrigger[0] === lvl[0]) tn = k;
        if (en < 0 && channelEnable[0] === lvl[0]) en = k;
        if (channelTrigger[0] === lvl[0]) ts++;
        if (channelEnable[0] === lvl[0]) es++;
      end
      check_count("trigger delay", 3 + (lvl ? rt : ft), tn);
      check_count("enable delay", 3 + et, en);
      check_count("trigger hold", 38 - (lvl ? rt : ft), ts);
      check_count("enable hold", 38 - et, es);
    end
  endtask : measure

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Cuts a hang short
  initial begin
    repeat (40000) @(posedge refClk);
    mismatches++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    {statusWrite, statusWriteData, softTriggerSignal, softTriggerOut, oscillatorPulse} = '0;
    {terminalInput, generatorOutput, generatorRunning, triggerInvert, enableInvert} = '0;
    {triggerSourceSelect, enableSourceSelect, triggerRiseDelay, triggerFallDelay} = '0;
    {enableDelay, mapEnable, mapPattern, trilevelPair, stModel} = '0;
    mapTarget = PSCR_MAP_TRIGGER;
    resetN = 1'b0;
    clkEn = 1'b1;
    masterEnable = 1'b1;
    settle(16);
    resetN = 1'b1;
    settle(4);
    compare_all();
    end_test("reset");
    write_status(11'h001);
    enableInvert = 4'hf;
    {terminalInput, generatorOutput, generatorRunning, softTriggerSignal} = 16'hb5a7;
    for (int k = 0; k < 40; k++) begin
      triggerSourceSelect = {4{pscr_sel_t'(k / 2)}};
      triggerInvert = k[0] ? 4'h5 : 4'ha;
      settle(10);
      compare_all();
    end
    end_test("sources");
    triggerSourceSelect = '0;
    trilevelPair = 2'b11;
    for (int v = 0; v < 16; v++) begin
      enableInvert = {~v[3], ~v[1], v[3], v[1]};
      triggerInvert = {~v[2], ~v[0], v[2], v[0]};
      settle(10);
      compare_all();
    end
    end_test("trilevel");
    trilevelPair = 2'b00;
    mapEnable = 1'b1;
    mapPattern = 20'h96c3a;
    for (int k = 0; k < 32; k++) begin
      mapTarget = pscr_map_target_t'(k / 16);
      triggerInvert = 4'(k);
      enableInvert = 4'(~k);
      settle(10);
      compare_all();
    end
    mapEnable = 1'b0;
    end_test("mapping");
    for (int k = 0; k < 256; k++) begin
      masterEnable = k[7];
      softTriggerOut = k[0];
      write_status({4'hf, 7'(k)});
      settle(8);
      compare_all();
    end
    clkEn = 1'b0;
    write_status(11'h07e);
    clkEn = 1'b1;
    settle(8);
    compare_all();
    end_test("status");
    write_status(11'h001);
    {triggerInvert, enableInvert, softTriggerSignal} = '0;
    triggerSourceSelect[0] = `PSCR_SEL_SOFT;
    enableSourceSelect[0] = `PSCR_SEL_SOFT;
    measure(0, 15, 0);
    measure(15, 0, 15);
    measure(7, 3, 9);
    triggerSourceSelect[0] = `PSCR_SEL_OSC;
    {triggerRiseDelay[0], triggerFallDelay[0]} = '0;
    settle(10);
    oscillatorPulse = 1'b1;
    n = 0;
    repeat (20) begin
      @(negedge refClk);
      if (channelTrigger[0] === 1'b1) n++;
    end
    check_count("oscillator pulse", `PSCR_OSC_CYCLES, n);
    oscillatorPulse = 1'b0;
    end_test("delays");
    for (int i = 0; i < 60; i++) begin
      for (int c = 0; c < 4; c++) begin
        triggerSourceSelect[c] = pscr_sel_t'(xorshift() % 20);
        enableSourceSelect[c] = pscr_sel_t'(xorshift() % 20);
        r = xorshift();
        {triggerRiseDelay[c], triggerFallDelay[c], enableDelay[c]} = r[11:0];
      end
      r = xorshift();
      {triggerInvert, enableInvert, generatorOutput, generatorRunning} = r[15:0];
      {terminalInput, softTriggerSignal, mapEnable, trilevelPair} = r[26:16];
      mapTarget = pscr_map_target_t'(r[27]);
      masterEnable = r[28] | r[29];
      softTriggerOut = r[30];
      r = xorshift();
      mapPattern = r[19:0];
      write_status(pscr_status_t'(xorshift()));
      settle(40);
      compare_all();
    end
    end_test("random");
    check("rail shorts", 32'h0, shortCount);
    report_and_stop();
  end
endmodule : power_switch_control_router_test
